// File: include/sfc_pkg.sv
// Constants and types for the serial flash command front end
package sfc_pkg;
   // ==========================================
   // Opcodes
   localparam logic [7:0] OP_WREN   = 8'h06;
   localparam logic [7:0] OP_WRDI   = 8'h04;
   localparam logic [7:0] OP_VWREN  = 8'h50;
   localparam logic [7:0] OP_RDSR1  = 8'h05;
   localparam logic [7:0] OP_RDSR2  = 8'h35;
   localparam logic [7:0] OP_RDSR3  = 8'h15;
   localparam logic [7:0] OP_WRSR1  = 8'h01;
   localparam logic [7:0] OP_WRSR2  = 8'h31;
   localparam logic [7:0] OP_WRSR3  = 8'h11;
   localparam logic [7:0] OP_RDEXT  = 8'hC8;
   localparam logic [7:0] OP_WREXT  = 8'hC5;
   localparam logic [7:0] OP_WRTPE  = 8'h56;
   localparam logic [7:0] OP_WRPAT  = 8'h4A;
   localparam logic [7:0] OP_EN4B   = 8'hB7;
   localparam logic [7:0] OP_EX4B   = 8'hE9;
   localparam logic [7:0] OP_READ   = 8'h03;
   localparam logic [7:0] OP_FREAD  = 8'h0B;
   localparam logic [7:0] OP_READ4  = 8'h13;
   localparam logic [7:0] OP_FREAD4 = 8'h0C;
   localparam logic [7:0] OP_DTR    = 8'hED;
   localparam logic [7:0] OP_DTR4   = 8'hEE;
   localparam logic [7:0] OP_PP     = 8'h02;
   localparam logic [7:0] OP_PP4    = 8'h12;
   localparam logic [7:0] OP_SE     = 8'h20;
   localparam logic [7:0] OP_SE4    = 8'h21;
   localparam logic [7:0] OP_BE32   = 8'h52;
   localparam logic [7:0] OP_BE32_4 = 8'h5C;
   localparam logic [7:0] OP_BE64   = 8'hD8;
   localparam logic [7:0] OP_BE64_4 = 8'hDC;
   localparam logic [7:0] OP_CE1    = 8'hC7;
   localparam logic [7:0] OP_CE2    = 8'h60;
   localparam logic [7:0] OP_RSTEN  = 8'h66;
   localparam logic [7:0] OP_RST    = 8'h99;

   // ==========================================
   // Register fields and reset values
   localparam int          EXT_UAB  = 0;
   localparam int          EXT_TPE  = 3;
   localparam logic [7:0]  EXT_MASK = 8'h09;
   localparam logic [7:0]  EXT_RST  = 8'h00;
   localparam logic [7:0]  PAT_RST  = 8'h34;
   localparam int          ST_WEL   = 1;
   localparam int          ST_ADS   = 16;
   localparam int          ST_ADP   = 20;
   localparam logic [23:0] ST_WMASK = 24'hF27AFC;
   localparam logic [23:0] ST_RST   = 24'h000000;

   // ==========================================
   // Link timing in serial clocks or clock edges, and FIFO size
   localparam logic [5:0] OPC_BITS     = 6'h08;
   localparam logic [5:0] DUMMY_CLKS   = 6'h08;
   localparam logic [5:0] DTR_DUM_EDGE = 6'h10;
   localparam logic [5:0] PAT_EDGES    = 6'h08;
   localparam int         FIFO_W       = 8;
   localparam int         FIFO_D       = 4;

   typedef enum logic [2:0] {
      PH_OPC   = 3'h0,
      PH_ADDR  = 3'h1,
      PH_DUMMY = 3'h3,
      PH_DOUT  = 3'h2,
      PH_DIN   = 3'h6,
      PH_IGN   = 3'h7
   } phase_t;

   typedef enum logic [2:0] {
      K_READ = 3'h0,
      K_PROG = 3'h1,
      K_SE   = 3'h2,
      K_BE32 = 3'h3,
      K_BE64 = 3'h4,
      K_CE   = 3'h5
   } kind_t;

   typedef struct packed {
      kind_t       kind;
      logic [31:0] addr;
   } array_cmd_t;

   typedef struct packed {
      logic [2:0] nab;
      logic       rd;
      logic       dum;
      logic       dtr;
      logic       din;
      logic       dout;
      logic       wr;
      kind_t      kind;
   } dec_t;
endpackage : sfc_pkg

// File: core/serial_flash_command_frontend.sv
// Serial flash command front end with its read-data FIFO
`timescale 1ns/1ps
// How it works
// - Upper bit 0 maps 3-byte addresses low
// - Upper bit 1 maps 3-byte addresses high
// - 4-byte mode needs four bytes, ignores bit
// - Four-byte address rewrites stored upper bit
// - Extension register: upper bit, pattern enable
// - C5H writes upper bit, 56H writes enable
// - Enabled pattern on four lines, last DTR dummies
// - Disabled pattern leaves lines undriven
// - 4AH stores a new volatile pattern byte
// - Power cycle restores default pattern
// - MSB first, sampled on rising clock, DTR address on both edges
// - Output data until select rises
// - Write commands need whole bytes
// - Partial program byte: nothing, latch kept
// - Mode commands prepend extension bits
// - Dedicated 4-byte commands ignore extension
// - Decode 06H, 04H, 50H in both modes
// - Status reads repeat their selected byte
// - Status writes 01H, 31H, 11H accepted
// - B7H enters, E9H exits 4-byte mode
// - 13H, 12H, 21H take four address bytes
// - 20H, 52H, D8H take three in 3-byte mode
// - 4-byte mode reads take four; 0BH dummy
// - Address width status shows current mode
// - Resets clear the extension register
// - C8H shifts register out on falling edges

// ==========================================
// Read-data FIFO
module sfc_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         flush_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DEPTH = (AW+1)'(D);
   logic [W-1:0] mem_r [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;

   assign in_ready_o  = (wp_r - rp_r) != DEPTH;
   assign out_valid_o = wp_r != rp_r;
   assign out_data_o  = mem_r[rp_r[AW-1:0]];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else if (flush_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         if (in_valid_i && in_ready_o) wp_r <= wp_r + 1'b1;
         if (out_valid_o && out_ready_i) rp_r <= rp_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (in_valid_i && in_ready_o && !flush_i) mem_r[wp_r[AW-1:0]] <= in_data_i;
   end
endmodule : sfc_fifo

// ==========================================
// Command front end
module serial_flash_command_frontend (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         sclk_i,
   input  wire logic         cs_b_i,
   input  wire logic [3:0]   io_i,
   output logic [3:0]        io_o,
   output logic [3:0]        io_oe_o,
   input  wire logic         power_up_addr4_i,
   input  wire logic [7:0]   rd_data_i,
   input  wire logic         rd_valid_i,
   output logic              rd_ready_o,
   output sfc_pkg::array_cmd_t cmd_o,
   output logic              cmd_valid_o,
   output logic [7:0]        prog_data_o,
   output logic              prog_valid_o
);
   import sfc_pkg::*;

   function automatic dec_t decode(input logic [7:0] op, input logic address_width_status);
      dec_t d;
      d = '0;
      case (op)
         OP_READ, OP_FREAD, OP_PP, OP_SE, OP_BE32, OP_BE64, OP_DTR:
            d.nab = address_width_status ? 3'h4 : 3'h3;
         OP_READ4, OP_FREAD4, OP_DTR4, OP_PP4, OP_SE4, OP_BE32_4, OP_BE64_4:
            d.nab = 3'h4;
         default: d.nab = 3'h0;
      endcase
      case (op)
         OP_READ, OP_READ4: d.rd = 1'b1;
         OP_FREAD, OP_FREAD4: begin
            d.rd  = 1'b1;
            d.dum = 1'b1;
         end
         OP_DTR, OP_DTR4: begin
            d.rd  = 1'b1;
            d.dum = 1'b1;
            d.dtr = 1'b1;
         end
         OP_PP, OP_PP4: begin
            d.din  = 1'b1;
            d.wr   = 1'b1;
            d.kind = K_PROG;
         end
         OP_SE, OP_SE4: begin
            d.wr   = 1'b1;
            d.kind = K_SE;
         end
         OP_BE32, OP_BE32_4: begin
            d.wr   = 1'b1;
            d.kind = K_BE32;
         end
         OP_BE64, OP_BE64_4: begin
            d.wr   = 1'b1;
            d.kind = K_BE64;
         end
         OP_CE1, OP_CE2: begin
            d.wr   = 1'b1;
            d.kind = K_CE;
         end
         OP_RDSR1, OP_RDSR2, OP_RDSR3, OP_RDEXT: d.dout = 1'b1;
         OP_WRSR1, OP_WRSR2, OP_WRSR3, OP_WREXT, OP_WRTPE, OP_WRPAT: d.din = 1'b1;
         default: d.kind = K_READ;
      endcase
      return d;
   endfunction : decode

   function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] n,
                                        input logic [7:0] m);
      return (o & ~m) | (n & m);
   endfunction : merge

   // ==========================================
   // Reset release and pin synchronisers
   logic [1:0]  rst_s_r;
   logic        rst_n;
   logic [2:0]  sclk_s_r;
   logic [2:0]  cs_s_r;
   logic [3:0]  io_s1_r;
   logic [3:0]  io_s2_r;
   logic [1:0]  strap_s_r;
   logic [1:0]  init_r;

   assign rst_n = rst_s_r[1];

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) rst_s_r <= 2'h0;
      else rst_s_r <= {rst_s_r[0], 1'b1};
   end

   // Third stage only remembers the previous level for edge detection
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s_r  <= 3'h0;
         cs_s_r    <= 3'h7;
         io_s1_r   <= 4'h0;
         io_s2_r   <= 4'h0;
         strap_s_r <= 2'h0;
         init_r    <= 2'h0;
      end else begin
         sclk_s_r  <= {sclk_s_r[1:0], sclk_i};
         cs_s_r    <= {cs_s_r[1:0], cs_b_i};
         io_s1_r   <= io_i;
         io_s2_r   <= io_s1_r;
         strap_s_r <= {strap_s_r[0], power_up_addr4_i};
         if (init_r != 2'h3) init_r <= init_r + 2'h1;
      end
   end

   // ==========================================
   // Frame sequencing
   logic        active;
   logic        rise_a;
   logic        fall_a;
   logic        edge_a;
   logic        cs_rise;
   phase_t      phase_r;
   dec_t        dec_r;
   dec_t        dec_nxt;
   logic [7:0]  op_r;
   logic [31:0] sh_r;
   logic [31:0] sh_nxt;
   logic [5:0]  cnt_r;
   logic [2:0]  bcnt_r;
   logic        samp;
   logic        opc_done;
   logic        addr_done;
   logic        din_byte;
   logic        ads_r;
   logic [7:0]  ext_r;

   assign active   = !cs_s_r[1];
   assign cs_rise  = cs_s_r[1] && !cs_s_r[2];
   assign rise_a   = active && sclk_s_r[1] && !sclk_s_r[2];
   assign fall_a   = active && !sclk_s_r[1] && sclk_s_r[2];
   assign edge_a   = rise_a || fall_a;
   assign samp     = (phase_r == PH_ADDR && dec_r.dtr) ? edge_a : rise_a;
   assign sh_nxt   = (phase_r == PH_ADDR && dec_r.dtr) ? {sh_r[27:0], io_s2_r}
                                                       : {sh_r[30:0], io_s2_r[0]};
   assign opc_done  = phase_r == PH_OPC && samp && cnt_r == 6'h01;
   assign addr_done = phase_r == PH_ADDR && samp && cnt_r == 6'h01;
   assign din_byte  = phase_r == PH_DIN && rise_a && bcnt_r == 3'h7;
   assign dec_nxt   = decode(sh_nxt[7:0], ads_r);

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= PH_OPC;
         cnt_r   <= OPC_BITS;
         bcnt_r  <= 3'h0;
         sh_r    <= 32'h0;
         op_r    <= 8'h00;
         dec_r   <= '0;
      end else if (!active) begin
         phase_r <= PH_OPC;
         cnt_r   <= OPC_BITS;
         bcnt_r  <= 3'h0;
      end else begin
         if (rise_a) bcnt_r <= bcnt_r + 3'h1;
         if (samp) sh_r <= sh_nxt;
         case (phase_r)
            PH_OPC: begin
               if (samp) cnt_r <= cnt_r - 6'h01;
               if (opc_done) begin
                  op_r  <= sh_nxt[7:0];
                  dec_r <= dec_nxt;
                  if (dec_nxt.nab != 3'h0) begin
                     phase_r <= PH_ADDR;
                     cnt_r   <= dec_nxt.dtr ? {2'h0, dec_nxt.nab, 1'b0}
                                            : {dec_nxt.nab, 3'h0};
                  end else if (dec_nxt.dout) phase_r <= PH_DOUT;
                  else if (dec_nxt.din) phase_r <= PH_DIN;
                  else phase_r <= PH_IGN;
               end
            end
            PH_ADDR: begin
               if (samp) cnt_r <= cnt_r - 6'h01;
               if (addr_done) begin
                  if (dec_r.dum) begin
                     phase_r <= PH_DUMMY;
                     cnt_r   <= dec_r.dtr ? DTR_DUM_EDGE : DUMMY_CLKS;
                  end else if (dec_r.rd) phase_r <= PH_DOUT;
                  else if (dec_r.din) phase_r <= PH_DIN;
                  else phase_r <= PH_IGN;
               end
            end
            PH_DUMMY: begin
               if (dec_r.dtr ? edge_a : rise_a) begin
                  cnt_r <= cnt_r - 6'h01;
                  if (cnt_r == 6'h01) phase_r <= PH_DOUT;
               end
            end
            PH_DOUT, PH_DIN, PH_IGN: phase_r <= phase_r;
            default: phase_r <= PH_IGN;
         endcase
      end
   end

   // ==========================================
   // Volatile state and commit at frame end
   logic        ok8;
   logic        wel_r;
   logic        vwen_r;
   logic        rsten_r;
   logic [7:0]  pat_r;
   logic [23:0] status_r;
   logic [23:0] st_view;
   logic [1:0]  din_cnt_r;
   logic [7:0]  sr0_r;
   logic [7:0]  sr1_r;
   logic        sw_ok;

   assign ok8   = bcnt_r == 3'h0;
   assign sw_ok = ok8 && (wel_r || vwen_r) && din_cnt_r != 2'h0 && phase_r == PH_DIN;

   always_comb begin
      st_view         = status_r;
      st_view[ST_WEL] = wel_r;
      st_view[ST_ADS] = ads_r;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         din_cnt_r <= 2'h0;
         sr0_r     <= 8'h00;
         sr1_r     <= 8'h00;
      end else if (!active) din_cnt_r <= 2'h0;
      else if (din_byte) begin
         if (din_cnt_r == 2'h0) sr0_r <= sh_nxt[7:0];
         if (din_cnt_r == 2'h1) sr1_r <= sh_nxt[7:0];
         if (din_cnt_r != 2'h3) din_cnt_r <= din_cnt_r + 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ext_r    <= EXT_RST;
         pat_r    <= PAT_RST;
         wel_r    <= 1'b0;
         vwen_r   <= 1'b0;
         rsten_r  <= 1'b0;
         ads_r    <= 1'b0;
         status_r <= ST_RST;
      end else begin
         if (init_r == 2'h2) begin
            ads_r            <= strap_s_r[1];
            status_r[ST_ADP] <= strap_s_r[1];
         end
         if (opc_done && sh_nxt[7:0] == OP_EN4B) ads_r <= 1'b1;
         if (opc_done && sh_nxt[7:0] == OP_EX4B) ads_r <= 1'b0;
         if (addr_done && dec_r.nab == 3'h4) ext_r[EXT_UAB] <= sh_nxt[24];
         if (din_byte && op_r == OP_WREXT) ext_r[EXT_UAB] <= sh_nxt[0];
         if (din_byte && op_r == OP_WRTPE) ext_r[EXT_TPE] <= sh_nxt[3];
         if (din_byte && op_r == OP_WRPAT) pat_r <= sh_nxt[7:0];
         if (cs_rise && phase_r != PH_OPC) begin
            vwen_r  <= ok8 && op_r == OP_VWREN;
            rsten_r <= ok8 && op_r == OP_RSTEN;
            if (ok8 && op_r == OP_WREN) wel_r <= 1'b1;
            if (ok8 && op_r == OP_WRDI) wel_r <= 1'b0;
            if (ok8 && dec_r.wr && wel_r && phase_r != PH_ADDR &&
                (!dec_r.din || din_cnt_r != 2'h0)) wel_r <= 1'b0;
            if (ok8 && op_r == OP_RST && rsten_r) begin
               ext_r <= EXT_RST;
               ads_r <= status_r[ST_ADP];
            end
            if (sw_ok) begin
               if (op_r == OP_WRSR1 || op_r == OP_WRSR2 || op_r == OP_WRSR3) wel_r <= 1'b0;
               if (op_r == OP_WRSR1)
                  status_r[7:0] <= merge(status_r[7:0], sr0_r, ST_WMASK[7:0]);
               if (op_r == OP_WRSR1 && din_cnt_r >= 2'h2)
                  status_r[15:8] <= merge(status_r[15:8], sr1_r, ST_WMASK[15:8]);
               if (op_r == OP_WRSR2)
                  status_r[15:8] <= merge(status_r[15:8], sr0_r, ST_WMASK[15:8]);
               if (op_r == OP_WRSR3)
                  status_r[23:16] <= merge(status_r[23:16], sr0_r, ST_WMASK[23:16]);
            end
         end
      end
   end

   // ==========================================
   // Array requests
   logic [31:0] ea;

   // Three-byte addresses take only the upper bit, reserved bits stay out
   assign ea = (dec_r.nab == 3'h4) ? sh_nxt
                                   : {7'h00, ext_r[EXT_UAB], sh_nxt[23:0]};

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cmd_o        <= '0;
         cmd_valid_o  <= 1'b0;
         prog_data_o  <= 8'h00;
         prog_valid_o <= 1'b0;
      end else begin
         cmd_valid_o  <= 1'b0;
         prog_valid_o <= din_byte && dec_r.kind == K_PROG && dec_r.wr;
         if (din_byte) prog_data_o <= sh_nxt[7:0];
         if (addr_done) cmd_o.addr <= ea;
         if (addr_done && dec_r.rd) begin
            cmd_o.kind  <= K_READ;
            cmd_valid_o <= 1'b1;
         end
         if (cs_rise && phase_r != PH_OPC && ok8 && dec_r.wr && wel_r &&
             phase_r != PH_ADDR && (!dec_r.din || din_cnt_r != 2'h0)) begin
            cmd_o.kind  <= dec_r.kind;
            cmd_valid_o <= 1'b1;
         end
      end
   end

   // ==========================================
   // Output shifter
   logic [7:0] src;
   logic [7:0] obyte_r;
   logic [2:0] oidx_r;
   logic       nib_r;
   logic       fetch;
   logic       fifo_v;
   logic [7:0] fifo_d;
   logic       pat_bit;
   logic       in_pat;

   assign fetch   = phase_r == PH_DOUT && (dec_r.dtr ? (edge_a && !nib_r)
                                                     : (fall_a && oidx_r == 3'h0));
   assign pat_bit = pat_r[cnt_r[2:0] - 3'h1];
   assign in_pat  = phase_r == PH_DUMMY && dec_r.dtr && edge_a && cnt_r <= PAT_EDGES;

   always_comb begin
      case (op_r)
         OP_RDSR1: src = st_view[7:0];
         OP_RDSR2: src = st_view[15:8];
         OP_RDSR3: src = st_view[23:16];
         OP_RDEXT: src = ext_r & EXT_MASK;
         default:  src = fifo_v ? fifo_d : 8'hFF;
      endcase
   end

   sfc_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_fifo (
      .clk_i      (sys_clk_i),
      .rst_n_i    (rst_n),
      .flush_i    (!active),
      .in_data_i  (rd_data_i),
      .in_valid_i (rd_valid_i),
      .in_ready_o (rd_ready_o),
      .out_data_o (fifo_d),
      .out_valid_o(fifo_v),
      .out_ready_i(fetch && dec_r.rd)
   );

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         io_o    <= 4'h0;
         io_oe_o <= 4'h0;
         obyte_r <= 8'h00;
         oidx_r  <= 3'h0;
         nib_r   <= 1'b0;
      end else if (!active) begin
         io_oe_o <= 4'h0;
         oidx_r  <= 3'h0;
         nib_r   <= 1'b0;
      end else if (in_pat) begin
         io_o    <= {4{pat_bit}};
         io_oe_o <= ext_r[EXT_TPE] ? 4'hF : 4'h0;
      end else if (phase_r == PH_DOUT && dec_r.dtr && edge_a) begin
         nib_r   <= !nib_r;
         io_oe_o <= 4'hF;
         if (!nib_r) begin
            io_o    <= src[7:4];
            obyte_r <= {src[3:0], 4'h0};
         end else io_o <= obyte_r[7:4];
      end else if (phase_r == PH_DOUT && fall_a) begin
         oidx_r  <= oidx_r + 3'h1;
         io_oe_o <= 4'h2;
         if (oidx_r == 3'h0) begin
            io_o[1] <= src[7];
            obyte_r <= {src[6:0], 1'b0};
         end else begin
            io_o[1] <= obyte_r[7];
            obyte_r <= {obyte_r[6:0], 1'b0};
         end
      end
   end

   // ==========================================
   // Checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   ext_reserved_a: assert property ((ext_r & ~EXT_MASK) == 8'h00)
      else $error("reserved extension bit set");
   lower_half_a: assert property (addr_done && dec_r.nab == 3'h3 && !ext_r[EXT_UAB]
      |=> cmd_o.addr[31:24] == 8'h00)
      else $error("3-byte address left lower half");
   upper_half_a: assert property (addr_done && dec_r.nab == 3'h3 && ext_r[EXT_UAB]
      |=> cmd_o.addr[31:24] == 8'h01)
      else $error("3-byte address left upper half");
   four_byte_a: assert property (opc_done && ads_r && dec_nxt.nab != 3'h0
      |=> dec_r.nab == 3'h4 && phase_r == PH_ADDR && cnt_r != 6'h18)
      else $error("4-byte mode took 3 address bytes");
   upper_update_a: assert property (addr_done && dec_r.nab == 3'h4
      |=> ext_r[EXT_UAB] == cmd_o.addr[24])
      else $error("upper bit not taken from address");
   pattern_off_a: assert property (phase_r == PH_DUMMY && dec_r.dtr && !ext_r[EXT_TPE]
      |=> io_oe_o == 4'h0)
      else $error("pattern driven while disabled");
   pattern_drive_a: assert property (in_pat && ext_r[EXT_TPE]
      |=> io_oe_o == 4'hF && io_o == {4{$past(pat_bit)}})
      else $error("pattern bit wrong");
   partial_byte_a: assert property (cs_rise && phase_r != PH_OPC && !ok8
      |=> !cmd_valid_o && wel_r == $past(wel_r))
      else $error("unaligned write command executed");
   partial_prog_a: assert property (cs_rise && dec_r.kind == K_PROG && dec_r.wr
      && phase_r == PH_DIN && !ok8 && wel_r |=> wel_r)
      else $error("partial program cleared latch");
endmodule : serial_flash_command_frontend

// File: verif/spi_host_model.sv
// Host controller model driving the serial link in single mode
`timescale 1ns/1ps
module spi_host_model (
   output logic            sclk_o,
   output logic            cs_b_o,
   output logic [3:0]      io_o,
   input  wire logic [3:0] dev_io_i,
   input  wire logic [3:0] dev_oe_i
);
   logic [7:0] rx;
   // ==========================================
   // Link tasks, mode 0
   initial begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      io_o   = 4'h5;
      rx     = 8'h00;
   end
   // Unused lines toggle so nothing reads as a held value
   task automatic bit_x(input logic b);
      io_o = {~io_o[3:1], b};
      #160;
      rx = {rx[6:0], dev_oe_i[1] ? dev_io_i[1] : ~rx[0]};
      sclk_o = 1'b1;
      #160;
      sclk_o = 1'b0;
   endtask : bit_x
   task automatic send(input logic [7:0] v, input int n);
      for (int i = 7; i > 7 - n; i--) bit_x(v[i]);
   endtask : send
   task automatic open_f;
      cs_b_o = 1'b0;
      #160;
   endtask : open_f
   task automatic close_f;
      cs_b_o = 1'b1;
      io_o = ~io_o;
      #400;
   endtask : close_f
endmodule : spi_host_model

// File: verif/test_serial_flash_command_frontend.sv
// Testbench for the serial flash command front end
`timescale 1ns/1ps
module test_serial_flash_command_frontend;
   import sfc_pkg::*;
   logic       sys_clk = 1'b0, rst_b = 1'b0, sclk, cs_b, cmd_valid, prog_valid, rd_ready;
   logic       up4 = 1'b0, rd_valid = 1'b1;
   logic [3:0] io_h, io_d, oe_d;
   logic [7:0] rd_data = 8'hA5, prog_data;
   array_cmd_t cmd, last_cmd;
   int         error_cnt = 0, checks = 0, cmd_n = 0, prog_n = 0;
   logic [23:0] rows [4] = '{{OP_WREXT, 8'hFF, 8'h01}, {OP_WRTPE, 8'hFF, 8'h09},
                             {OP_WREXT, 8'h00, 8'h08}, {OP_WRTPE, 8'hF7, 8'h00}};
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (cmd_valid === 1'b1) begin
      last_cmd <= cmd;
      cmd_n <= cmd_n + 1;
   end
   always @(posedge sys_clk) if (prog_valid === 1'b1) prog_n <= prog_n + 1;
   serial_flash_command_frontend i_serial_flash_command_frontend (.sys_clk_i(sys_clk),
      .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b), .io_i(io_h), .io_o(io_d), .io_oe_o(oe_d),
      .power_up_addr4_i(up4), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .rd_ready_o(rd_ready), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
      .prog_data_o(prog_data), .prog_valid_o(prog_valid));
   spi_host_model i_spi_host_model (.sclk_o(sclk), .cs_b_o(cs_b), .io_o(io_h),
      .dev_io_i(io_d), .dev_oe_i(oe_d));
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Opcode, then nb payload bits taken from the top of pay
   task automatic frame(input logic [7:0] op, input logic [31:0] pay, input int nb);
      @(negedge sys_clk);
      i_spi_host_model.open_f();
      i_spi_host_model.send(op, 8);
      for (int i = 31; i > 31 - nb; i--) i_spi_host_model.bit_x(pay[i]);
      i_spi_host_model.close_f();
   endtask : frame
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      frame(op, 32'h0, 8);
      check("read byte", {27'h0, i_spi_host_model.rx}, {27'h0, exp});
   endtask : rd
   task automatic do_reset;
      @(negedge sys_clk) rst_b = 1'b0;
      repeat (4) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (8) @(negedge sys_clk);
   endtask : do_reset
   task automatic end_of_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   // ==========================================
   // Tests
   initial begin
      #1_000_000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         frame(rows[i][23:16], {rows[i][15:8], 24'h0}, 8);
         rd(OP_RDEXT, rows[i][7:0]);
      end
      $display("test extension table done");
      // Leave both bits set so the reset has something to clear
      frame(OP_WREXT, 32'hFF000000, 8);
      frame(OP_WRTPE, 32'hFF000000, 8);
      do_reset();
      check("ready", {34'h0, rd_ready}, 35'h1);
      rd(OP_RDEXT, 8'h00);
      rd(OP_RDSR3, 8'h00);
      $display("test reset done");
      frame(OP_WREXT, 32'h01000000, 8);
      frame(OP_READ, 32'h12345600, 32);
      check("cmd", last_cmd, {K_READ, 32'h01123456});
      check("data", {27'h0, i_spi_host_model.rx}, {27'h0, rd_data});
      frame(OP_WREXT, 32'h0, 8);
      frame(OP_READ, 32'h12345600, 24);
      check("cmd", last_cmd, {K_READ, 32'h00123456});
      $display("test three byte reads done");
      frame(OP_EN4B, 32'h0, 0);
      rd(OP_RDSR3, 8'h01);
      frame(OP_READ, 32'h01ABCDEF, 32);
      check("cmd", last_cmd, {K_READ, 32'h01ABCDEF});
      rd(OP_RDEXT, 8'h01);
      frame(OP_READ4, 32'h00001234, 32);
      check("cmd", last_cmd, {K_READ, 32'h00001234});
      frame(OP_EX4B, 32'h0, 0);
      rd(OP_RDSR3, 8'h00);
      $display("test four byte mode done");
      @(negedge sys_clk);
      i_spi_host_model.open_f();
      i_spi_host_model.send(OP_WREN, 8);
      i_spi_host_model.bit_x(1'b0);
      i_spi_host_model.close_f();
      rd(OP_RDSR1, 8'h00);
      frame(OP_WREN, 32'h0, 0);
      rd(OP_RDSR1, 8'h02);
      // Partial program first, while the latch is still set
      @(negedge sys_clk);
      i_spi_host_model.open_f();
      i_spi_host_model.send(OP_PP, 8);
      for (int i = 0; i < 4; i++) i_spi_host_model.send(8'h5A, i < 3 ? 8 : 3);
      i_spi_host_model.close_f();
      check("commits", cmd_n, 4);
      check("prog bytes", prog_n, 0);
      rd(OP_RDSR1, 8'h02);
      frame(OP_PP, 32'h000100A5, 32);
      check("cmd", last_cmd, {K_PROG, 32'h00000100});
      check("prog data", {27'h0, prog_data}, {27'h0, 8'hA5});
      check("prog bytes", prog_n, 1);
      rd(OP_RDSR1, 8'h00);
      frame(OP_WREN, 32'h0, 0);
      frame(OP_WRDI, 32'h0, 0);
      rd(OP_RDSR1, 8'h00);
      $display("test write latch done");
      frame(OP_WREN, 32'h0, 0);
      frame(OP_WRSR1, 32'hFFFF0000, 16);
      rd(OP_RDSR1, ST_WMASK[7:0]);
      rd(OP_RDSR2, ST_WMASK[15:8]);
      $display("test status write done");
      // Host samples only on rises, so it sees pattern bits 7, 5, 3, 1
      frame(OP_WRTPE, 32'hFF000000, 8);
      frame(OP_WRPAT, 32'hA0000000, 8);
      frame(OP_DTR, 32'h0, 11);
      check("user pattern", {31'h0, i_spi_host_model.rx[3:0]}, 35'hC);
      do_reset();
      frame(OP_WRTPE, 32'hFF000000, 8);
      frame(OP_DTR, 32'h0, 11);
      check("pattern", {31'h0, i_spi_host_model.rx[3:0]},
            {31'h0, PAT_RST[7], PAT_RST[5], PAT_RST[3], PAT_RST[1]});
      frame(OP_WRTPE, 32'h0, 8);
      frame(OP_DTR, 32'h0, 11);
      // Undriven lines read back as the inverse of the previous sample
      check("no pattern", {31'h0, i_spi_host_model.rx[3:0] ^ i_spi_host_model.rx[4:1]},
            35'hF);
      $display("test learning pattern done");
      end_of_test();
   end
endmodule : test_serial_flash_command_frontend
